// ---- core/mfbfe_top.sv ----
// muxed flash bus front end: address latch, burst control, ready, write gating
`timescale 1ns/1ps
`default_nettype none
`include "mfbfe_defs.svh"
module mfbfe_top #(
    parameter int TOP_BIT = `MFBFE_TOP_BIT_LARGE, // 24, 23 or 22
    parameter int LATENCY = `MFBFE_LATENCY // clocks before first word
) (
    input wire logic clock_i, // burst clock from host
    input wire logic rstn_i, // hardware reset, active low
    input wire logic chip_enable_n_i, // chip enable, active low
    input wire logic output_enable_n_i, // output enable, active low
    input wire logic write_enable_n_i, // write enable, active low
    input wire logic address_valid_strobe_n_i, // address valid, active low
    input wire logic [TOP_BIT:16] addr_hi_i, // address-only inputs
    input wire logic [15:0] shared_addr_data_pins_i, // pin level in
    output logic [15:0] shared_addr_data_pins_o, // pin drive value
    output logic shared_addr_data_pins_oe_o, // high while driving pins
    input wire logic write_protect_n_i, // write protect, active low
    input wire mfbfe_pkg::mfbfe_pv_t accel_level_i, // accelerate pin level
    input wire logic [15:0] array_data_i, // word read from array
    output logic [TOP_BIT:0] array_addr_o, // word address to array
    output logic [3:0] array_bank_o, // selected bank
    output logic array_read_mode_o, // array read mode active
    output logic program_allow_o, // program/erase allowed at address
    output logic unlock_bypass_o, // unlock bypass programming mode
    output logic fast_program_o, // accelerated programming
    output logic burst_active_o, // burst in progress
    output logic ready_o // burst data valid
);
    import mfbfe_pkg::*;
    localparam int AW = TOP_BIT + 1;
    localparam logic [7:0] LAT = 8'(LATENCY);

    typedef struct packed {
        mfbfe_state_t state;
        logic [AW-1:0] addr;
        logic [7:0] wait_cnt;
        logic [15:0] dout;
        logic rdy;
        logic read_mode;
    } mfbfe_regs_t;

    mfbfe_regs_t cur_ff, nxt_cur;
    logic ce;
    logic strobe;
    logic [AW-1:0] pin_addr;
    logic cnt_load;
    logic cnt_step;
    logic [AW-1:0] cnt_addr;
    logic wr_gate;

    mfbfe_addr_if #(.AW(AW)) aif ();

    assign ce = !chip_enable_n_i;
    assign strobe = !address_valid_strobe_n_i;
    assign pin_addr = {addr_hi_i, shared_addr_data_pins_i};

    always_comb
    begin
        nxt_cur = cur_ff;
        cnt_load = 1'b0;
        cnt_step = 1'b0;
        nxt_cur.rdy = 1'b0;
        if (!ce)
        begin
            // deselect ends any access; strobe and clock ignored
            nxt_cur.state = MFBFE_IDLE;
        end
        else if (strobe)
        begin
            // strobe low: pins carry address, latch it
            nxt_cur.addr = pin_addr;
            nxt_cur.read_mode = 1'b1;
            cnt_load = 1'b1;
            nxt_cur.wait_cnt = LAT;
            nxt_cur.state = MFBFE_WAIT;
        end
        else
        begin
            // strobe high: address inputs disregarded
            case (cur_ff.state)
                MFBFE_IDLE:
                    nxt_cur.state = MFBFE_IDLE;
                MFBFE_ASYNC:
                    nxt_cur.state = MFBFE_ASYNC;
                MFBFE_WAIT:
                begin
                    if (cur_ff.wait_cnt <= 8'h01)
                    begin
                        // first word leaves now, so the counter moves on to the second
                        cnt_step = 1'b1;
                        nxt_cur.state = MFBFE_BURST;
                        nxt_cur.dout = array_data_i;
                        nxt_cur.rdy = 1'b1;
                    end
                    else
                        nxt_cur.wait_cnt = cur_ff.wait_cnt - 8'h01;
                end
                MFBFE_BURST:
                begin
                    cnt_step = 1'b1;
                    nxt_cur.dout = array_data_i;
                    nxt_cur.rdy = 1'b1;
                end
                default:
                    nxt_cur.state = MFBFE_IDLE;
            endcase
        end
    end

    // reset returns to array read with no access open
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cur_ff.state <= MFBFE_IDLE;
            cur_ff.addr <= '0;
            cur_ff.wait_cnt <= 8'h00;
            cur_ff.dout <= 16'h0000;
            cur_ff.rdy <= 1'b0;
            cur_ff.read_mode <= 1'b1;
        end
        else
            cur_ff <= nxt_cur;
    end

    mfbfe_burst_cnt #(.AW(AW)) u_cnt (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .load_i(cnt_load),
        .start_i(pin_addr),
        .step_i(cnt_step),
        .addr_o(cnt_addr)
    );

    assign aif.addr = cur_ff.addr;
    assign aif.valid = 1'b1;
    mfbfe_bank_dec #(.TOP_BIT(TOP_BIT)) u_dec (
        .a(aif)
    );

    // program/erase gating by protect and accelerate levels
    assign wr_gate = (accel_level_i != MFBFE_PV_LOW)
        && !(!write_protect_n_i && aif.top_sector);
    assign program_allow_o = wr_gate;
    assign unlock_bypass_o = (accel_level_i == MFBFE_PV_ELEV);
    assign fast_program_o = (accel_level_i == MFBFE_PV_ELEV);

    // output enable and chip enable act directly, no clock sampling
    assign shared_addr_data_pins_oe_o = ce && !output_enable_n_i && write_enable_n_i
        && !strobe;
    assign shared_addr_data_pins_o = (cur_ff.state == MFBFE_BURST) ? cur_ff.dout
        : array_data_i;
    assign array_addr_o = (cur_ff.state == MFBFE_BURST) ? cnt_addr : cur_ff.addr;
    assign array_bank_o = aif.bank;
    assign array_read_mode_o = cur_ff.read_mode;
    assign burst_active_o = (cur_ff.state == MFBFE_BURST);
    assign ready_o = cur_ff.rdy && ce;

    start_latch_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (ce && strobe) |=> (cur_ff.state == MFBFE_WAIT && cur_ff.addr == $past(pin_addr)))
        else $error("address not captured on strobe");
    strobe_ignore_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (!strobe) |=> (cur_ff.addr == $past(cur_ff.addr)))
        else $error("address changed with strobe high");
    burst_step_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (ce && !strobe && cur_ff.state == MFBFE_BURST) |=> (cnt_addr == $past(cnt_addr) + AW'(1)))
        else $error("burst counter did not advance");
    ready_late_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (ready_o && !burst_active_o) |-> 1'b0)
        else $error("ready outside burst");
    deselect_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (!ce) |=> (cur_ff.state == MFBFE_IDLE && !ready_o))
        else $error("activity while deselected");
    accel_low_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (accel_level_i == MFBFE_PV_LOW) |-> !program_allow_o)
        else $error("program allowed with accelerate low");
    protect_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (!write_protect_n_i && aif.top_sector) |-> !program_allow_o)
        else $error("protected sector not blocked");
    bypass_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (accel_level_i == MFBFE_PV_ELEV) |-> (unlock_bypass_o && fast_program_o))
        else $error("elevated level did not enter bypass");
endmodule : mfbfe_top
`default_nettype wire

// ---- core/mfbfe_defs.svh ----
// constants shared by the muxed flash bus front end
`ifndef MFBFE_DEFS_SVH
`define MFBFE_DEFS_SVH
`define MFBFE_LOW_ADDR_W 16
`define MFBFE_TOP_BIT_LARGE 24
`define MFBFE_BANK_COUNT 16
`define MFBFE_PROT_SECTORS 4
`define MFBFE_SECTOR_ADDR_W 16
`define MFBFE_LATENCY 4
`define MFBFE_ADDR_RST 25'h0000000
`endif

// ---- core/mfbfe_pkg.sv ----
// types of the muxed flash bus front end
package mfbfe_pkg;
    typedef enum logic [1:0] {MFBFE_IDLE, MFBFE_ASYNC, MFBFE_WAIT, MFBFE_BURST} mfbfe_state_t;
    typedef enum logic [1:0] {MFBFE_PV_LOW, MFBFE_PV_HIGH, MFBFE_PV_ELEV} mfbfe_pv_t;
endpackage : mfbfe_pkg

// ---- core/mfbfe_addr_if.sv ----
// address hand-off between bus front end and the bank decoder
`timescale 1ns/1ps
`default_nettype none
interface mfbfe_addr_if #(parameter int AW = 25);
    logic [AW-1:0] addr;
    logic valid;
    logic [3:0] bank;
    logic top_sector;
    modport src (output addr, output valid, input bank, input top_sector);
    modport dec (input addr, input valid, output bank, output top_sector);
endinterface : mfbfe_addr_if
`default_nettype wire

// ---- core/mfbfe_bank_dec.sv ----
// bank select and top-sector detect for the latched address
`timescale 1ns/1ps
`default_nettype none
`include "mfbfe_defs.svh"
module mfbfe_bank_dec #(
    parameter int TOP_BIT = `MFBFE_TOP_BIT_LARGE
) (
    mfbfe_addr_if.dec a // latched address in, decode out
);
    import mfbfe_pkg::*;
    localparam int SW = TOP_BIT + 1 - `MFBFE_SECTOR_ADDR_W;
    localparam logic [SW-1:0] PROT_FIRST = SW'((1 << SW) - `MFBFE_PROT_SECTORS);
    logic [SW-1:0] sector;
    assign sector = a.addr[TOP_BIT:`MFBFE_SECTOR_ADDR_W];
    // four msbs of the address pick one of sixteen banks in every variant
    assign a.bank = a.addr[TOP_BIT -: 4];
    assign a.top_sector = a.valid && (sector >= PROT_FIRST);
endmodule : mfbfe_bank_dec
`default_nettype wire

// ---- core/mfbfe_burst_cnt.sv ----
// burst address counter
`timescale 1ns/1ps
`default_nettype none
module mfbfe_burst_cnt #(
    parameter int AW = 25
) (
    input wire logic clock_i, // clock
    input wire logic rstn_i, // async reset, active low
    input wire logic load_i, // load start address
    input wire logic [AW-1:0] start_i, // start address
    input wire logic step_i, // advance by one word
    output logic [AW-1:0] addr_o // current address
);
    typedef struct packed {logic [AW-1:0] addr;} mfbfe_cnt_t;
    mfbfe_cnt_t cur_ff, nxt_cur;
    always_comb
    begin
        nxt_cur = cur_ff;
        if (load_i)
            nxt_cur.addr = start_i;
        else if (step_i)
            nxt_cur.addr = cur_ff.addr + AW'(1);
    end
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end
    assign addr_o = cur_ff.addr;
endmodule : mfbfe_burst_cnt
`default_nettype wire

// ---- testbench/mfbfe_array_model.sv ----
// array word source seen by the front end
`timescale 1ns/1ps
`default_nettype none
module mfbfe_array_model #(
    parameter int AW = 25
) (
    input wire logic [AW-1:0] addr_i, // word address
    output logic [15:0] data_o // word at that address
);
    // every word differs from its neighbours so a stuck counter shows
    assign data_o = addr_i[15:0] ^ 16'h5A3C ^ 16'(addr_i[AW-1:16]);
endmodule : mfbfe_array_model
`default_nettype wire

// ---- testbench/muxed_flash_bus_front_end_tb.sv ----
// self-checking bench for the muxed flash bus front end
`timescale 1ns/1ps
`default_nettype none
module muxed_flash_bus_front_end_tb;
    import mfbfe_pkg::*;
    localparam int TB = 24;
    localparam int LAT = 4;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_n = 1'b1;
    logic oe_n = 1'b1;
    logic avd_n = 1'b1;
    logic wp_n = 1'b1;
    logic watch = 1'b1;
    mfbfe_pv_t accel = MFBFE_PV_HIGH;
    logic [TB:16] addr_hi = '0;
    logic [15:0] host_lo = 16'h0000;
    logic [15:0] pins_in, pins_out, arr_data;
    logic pins_oe, read_mode, allow, bypass, fastp, bactive, rdy;
    logic [TB:0] arr_addr;
    logic [3:0] bank;
    logic [31:0] rnd;
    logic [15:0] exp_q[$];
    int fail_count = 0;
    int n_compared = 0;
    // every access here is a burst, so the clock may run free
    always #5 clock_i = ~clock_i;
    assign pins_in = pins_oe ? pins_out : host_lo;
    mfbfe_top #(.TOP_BIT(TB), .LATENCY(LAT)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .chip_enable_n_i(ce_n), .output_enable_n_i(oe_n), .write_enable_n_i(1'b1),
        .address_valid_strobe_n_i(avd_n), .addr_hi_i(addr_hi), .shared_addr_data_pins_i(pins_in),
        .shared_addr_data_pins_o(pins_out), .shared_addr_data_pins_oe_o(pins_oe),
        .write_protect_n_i(wp_n), .accel_level_i(accel), .array_data_i(arr_data),
        .array_addr_o(arr_addr), .array_bank_o(bank), .array_read_mode_o(read_mode),
        .program_allow_o(allow), .unlock_bypass_o(bypass), .fast_program_o(fastp),
        .burst_active_o(bactive), .ready_o(rdy));
    mfbfe_array_model #(.AW(TB + 1)) u_array (.addr_i(arr_addr), .data_o(arr_data));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic capture(input logic [TB:0] a);
        @(posedge clock_i);
        ce_n <= 1'b0;
        avd_n <= 1'b0;
        addr_hi <= a[TB:16];
        host_lo <= a[15:0];
        @(posedge clock_i);
        avd_n <= 1'b1;
        rnd = $urandom;
        addr_hi <= rnd[TB:16];
        host_lo <= rnd[15:0];
    endtask : capture
    task automatic burst(input logic [TB:0] a, input int n);
        int k;
        logic [TB:0] w;
        for (k = 0; k < n; k++)
        begin
            w = a + (TB + 1)'(k);
            exp_q.push_back(w[15:0] ^ 16'h5A3C ^ 16'(w[TB:16]));
        end
        capture(a);
        k = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            k++;
        end while (rdy !== 1'b1 && k < 20);
        chk("first ready edge", k, LAT);
        if (rdy !== 1'b1)
            end_of_test();
        chk("bank", bank, a[TB-:4]);
        chk("burst flag", bactive, 1);
        repeat (n) @(posedge clock_i);
        ce_n <= 1'b1;
        @(posedge clock_i);
        #1;
        chk("ready after deselect", rdy, 0);
        chk("words left", exp_q.size(), 0);
    endtask : burst
    task automatic gating(input logic [TB:0] a, input logic top);
        int i;
        watch = 1'b0;
        capture(a);
        for (i = 0; i < 6; i++)
        begin
            @(posedge clock_i);
            accel <= mfbfe_pv_t'(i % 3);
            wp_n <= (i >= 3);
            #1;
            chk("program allow", allow, (i % 3 != 0) && !(i < 3 && top));
            chk("bypass", bypass, i % 3 == 2);
            chk("fast program", fastp, i % 3 == 2);
        end
        ce_n <= 1'b1;
        accel <= MFBFE_PV_HIGH;
        repeat (2) @(posedge clock_i);
        watch = 1'b1;
    endtask : gating
    always @(posedge clock_i)
        if (rstn_i === 1'b1 && watch && rdy === 1'b1)
        begin
            chk("pin drive", pins_oe, 1);
            if (exp_q.size() == 0)
                chk("unexpected ready", 1, 0);
            else
                chk("burst word", pins_out, exp_q.pop_front());
        end
    initial
    begin
        void'($urandom(73));
        repeat (8) @(posedge clock_i);
        chk("reset read mode", read_mode, 1);
        chk("reset ready", rdy, 0);
        rstn_i <= 1'b1;
        oe_n <= 1'b0;
        burst(25'h000FFFE, 5);
        rnd = $urandom;
        burst(rnd[TB:0], 3);
        burst(25'h1FFFFFF, 2);
        @(posedge clock_i);
        avd_n <= 1'b0;
        repeat (LAT + 2) @(posedge clock_i);
        avd_n <= 1'b1;
        chk("deselected start", bactive, 0);
        gating(25'h1FD1234, 1'b1);
        gating(25'h0AB0042, 1'b0);
        watch = 1'b0;
        capture(25'h0420000);
        repeat (LAT + 1) @(posedge clock_i);
        rstn_i <= 1'b0;
        #1;
        chk("mid reset read mode", read_mode, 1);
        chk("mid reset burst", bactive, 0);
        chk("mid reset ready", rdy, 0);
        @(posedge clock_i);
        rstn_i <= 1'b1;
        ce_n <= 1'b1;
        @(posedge clock_i);
        watch = 1'b1;
        burst(25'h0420010, 4);
        end_of_test();
    end
endmodule : muxed_flash_bus_front_end_tb
`default_nettype wire
